// [rtl/reload_downcounter_pwm_buzzer.sv]
// Purpose: 10-bit auto-reload down-counter with prescaler, PWM and buzzer on one pin.
// Assumes: Count pin synchronous to clk_sys_i; instruction clock is every clk_sys_i cycle.
// Notes:   FLAG_BIT and IE_BIT select the second or third instance layout.
//
// Implementation choices: the register addresses and the strobed register port.
`include "reload_timer_defines.svh"
module reload_downcounter_pwm_buzzer #(
  parameter int FLAG_BIT = 5,
  parameter int IE_BIT   = 5
) (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_n_i,
  // Register port
  input  wire reload_timer_pkg::bus_req_type bus_i,
  output logic [7:0]                         rdata_o,
  // External count pin
  input  wire logic                          external_count_pin_i,
  // Shared output pin
  output reload_timer_pkg::pin_drive_type    pin_o,
  // Interrupt
  output logic                               irq_o,
  output logic                               underflow_flag_o
);

  import reload_timer_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [7:0] reload_duty_high_bits;
  logic [7:0] buzzer_control;
  logic [7:0] irq_enable_reg;
  logic       global_irq_enable;
  logic [9:0] reload_value;
  logic [9:0] duty_buffer;
  logic [9:0] pwm_duty_value;
  logic [9:0] count;
  logic [9:0] next_count;
  logic       pin_last;
  logic       underflow;
  logic       timer_tick;
  logic       presc_tick;
  logic [7:0] prescaler_value_readback;
  logic       src_tick;
  logic       base_tick;
  logic       pwm_active;
  logic       buzzer_output;
  logic       timer_run_enable;
  logic       wr_ctrl_two;
  logic       wr_reload_low;
  run_state_type run_state;

  assign timer_run_enable = timer_control_one[`BIT_RUN_ENABLE];
  assign wr_ctrl_two      = bus_i.wr && (bus_i.addr == `OFS_CONTROL_TWO);
  assign wr_reload_low    = bus_i.wr && (bus_i.addr == `OFS_RELOAD_LOW);

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      timer_control_one     <= `RST_BYTE;
      timer_control_two     <= `RST_BYTE;
      reload_duty_high_bits <= `RST_BYTE;
      buzzer_control        <= `RST_BYTE;
      irq_enable_reg        <= `RST_BYTE;
      global_irq_enable     <= 1'b0;
      reload_value          <= `RST_COUNT;
      duty_buffer           <= `ZERO_COUNT;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `OFS_CONTROL_ONE) begin
        timer_control_one <= bus_i.wdata;
      end else if (bus_i.addr == `OFS_CONTROL_TWO) begin
        timer_control_two <= bus_i.wdata;
      end else if (bus_i.addr == `OFS_HIGH_BITS) begin
        reload_duty_high_bits <= bus_i.wdata;
      end else if (bus_i.addr == `OFS_RELOAD_LOW) begin
        // The high bits were written first, so the pair forms one value.
        reload_value <= {reload_duty_high_bits[`BIT_RELOAD_HI +: 2], bus_i.wdata};
      end else if (bus_i.addr == `OFS_DUTY_LOW) begin
        duty_buffer <= {reload_duty_high_bits[`BIT_DUTY_HI +: 2], bus_i.wdata};
      end else if (bus_i.addr == `OFS_BUZZER_CTRL) begin
        buzzer_control <= bus_i.wdata;
      end else if (bus_i.addr == `OFS_IRQ_ENABLE) begin
        irq_enable_reg <= bus_i.wdata;
      end else if (bus_i.addr == `OFS_GLOBAL_IRQ) begin
        global_irq_enable <= bus_i.wdata[`BIT_GLOBAL_IRQ];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Count source and prescaler
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_last <= 1'b0;
    end else begin
      pin_last <= external_count_pin_i;
    end
  end

  always_comb begin
    if (timer_control_two[`BIT_SRC_SEL]) begin
      if (timer_control_two[`BIT_EDGE_SEL]) begin
        base_tick = pin_last && !external_count_pin_i;
      end else begin
        base_tick = !pin_last && external_count_pin_i;
      end
    end else begin
      base_tick = 1'b1;
    end
  end

  // The prescaler is cleared whenever control two is written so a new ratio starts clean.
  ratio_divider u_prescaler (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (wr_ctrl_two),
    .tick_i    (base_tick && timer_run_enable),
    .sel_i     (timer_control_two[2:0]),
    .tick_o    (presc_tick),
    .count_o   (prescaler_value_readback)
  );

  // The bypass path adds no delay, the prescaled path adds one cycle.
  assign src_tick   = timer_control_two[`BIT_PRESC_EN_N] ?
                      (base_tick && timer_run_enable) : presc_tick;
  assign timer_tick = src_tick && timer_run_enable && (run_state == COUNT_RUN);
  assign underflow  = timer_tick && (count == `ZERO_COUNT);

  // --------------------------------------------------------------------------
  // Down-counter
  // --------------------------------------------------------------------------
  always_comb begin
    if (timer_control_one[`BIT_RELOAD_SEL]) begin
      next_count = reload_value;
    end else begin
      next_count = `FULL_SCALE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count     <= `RST_COUNT;
      run_state <= COUNT_RUN;
    end else if (wr_reload_low && !timer_run_enable) begin
      count     <= {reload_duty_high_bits[`BIT_RELOAD_HI +: 2], bus_i.wdata};
      run_state <= COUNT_RUN;
    end else if (underflow) begin
      if (timer_control_one[`BIT_ONE_SHOT]) begin
        run_state <= COUNT_STOPPED;
      end else begin
        count <= next_count;
      end
    end else if (timer_tick) begin
      count <= count - 10'h001;
    end else if (!timer_run_enable) begin
      run_state <= COUNT_RUN;
    end
  end

  // --------------------------------------------------------------------------
  // PWM
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pwm_duty_value <= `ZERO_COUNT;
    end else if (underflow) begin
      pwm_duty_value <= duty_buffer;
    end
  end

  // Active while the count lies below the duty, giving duty input clocks per frame.
  assign pwm_active = (pwm_duty_value != `ZERO_COUNT) && (count < pwm_duty_value);

  buzzer_gen u_buzzer (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (buzzer_control[`BIT_BUZZER_EN]),
    .presc_tick_i (presc_tick),
    .timer_tick_i (underflow),
    .freq_sel_i   (buzzer_control[3:0]),
    .wave_o       (buzzer_output)
  );

  // --------------------------------------------------------------------------
  // Shared pin
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_o <= '0;
    end else if (timer_control_one[`BIT_PWM_OE]) begin
      pin_o.pin_oe  <= 1'b1;
      pin_o.pin_out <= pwm_active ^ timer_control_one[`BIT_PWM_LOW];
    end else if (buzzer_control[`BIT_BUZZER_EN]) begin
      pin_o.pin_oe  <= 1'b1;
      pin_o.pin_out <= buzzer_output;
    end else begin
      pin_o <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // Flag and interrupt
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      underflow_flag_o <= 1'b0;
    end else if (underflow) begin
      underflow_flag_o <= 1'b1;
    end else if (bus_i.wr && (bus_i.addr == `OFS_IRQ_FLAG) && !bus_i.wdata[FLAG_BIT]) begin
      underflow_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= underflow_flag_o && irq_enable_reg[IE_BIT] && global_irq_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      if (bus_i.addr == `OFS_CONTROL_ONE) begin
        rdata_o <= timer_control_one;
      end else if (bus_i.addr == `OFS_CONTROL_TWO) begin
        rdata_o <= timer_control_two;
      end else if (bus_i.addr == `OFS_HIGH_BITS) begin
        rdata_o <= {count[9:8], reload_duty_high_bits[5:0]};
      end else if (bus_i.addr == `OFS_RELOAD_LOW) begin
        rdata_o <= count[7:0];
      end else if (bus_i.addr == `OFS_DUTY_LOW) begin
        rdata_o <= duty_buffer[7:0];
      end else if (bus_i.addr == `OFS_PRESCALE_RB) begin
        rdata_o <= prescaler_value_readback;
      end else if (bus_i.addr == `OFS_BUZZER_CTRL) begin
        rdata_o <= buzzer_control;
      end else if (bus_i.addr == `OFS_IRQ_FLAG) begin
        rdata_o <= 8'(underflow_flag_o) << FLAG_BIT;
      end else if (bus_i.addr == `OFS_IRQ_ENABLE) begin
        rdata_o <= irq_enable_reg;
      end else if (bus_i.addr == `OFS_GLOBAL_IRQ) begin
        rdata_o <= {7'h00, global_irq_enable};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : reload_downcounter_pwm_buzzer

// [pkg/reload_timer_defines.svh]
// Purpose: Offsets, field positions, reset values and counts of the reload down-counter.
// Assumes: Byte-wide registers on a plain strobe port, 10 MHz system clock.
// Notes:   Definitions only.
// Notes on behaviour
// - 10-bit down-counter, prescaler, drives PWM, buzzer.
// - High bits first; reload moves at overflow.
// - Disabled timer loads on low byte write.
// - Timer read returns present count.
// - Counter runs only with run enable.
// - Source select picks pin or instruction clock.
// - Edge select: one falling, zero rising.
// - Prescaler inserted when enable bit low.
// - Prescaler count readable in own register.
// - One-shot counts down once then stops.
// - Reload select restores initial value.
// - Otherwise restart from 0x3ff.
// - Underflow sets sticky flag; firmware clears.
// - Interrupt needs flag, enable and global.
// - PWM enable drives pin as output.
// - Polarity bit one means active low.
// - Duty gives active input clocks per frame.
// - Duty high bits first; moves at overflow.
// - Buzzer enable drives shared pin as output.
// - Buzzer source prescaler or timer, divided.
// - Third instance uses other flag bits.
`ifndef RELOAD_TIMER_DEFINES_SVH
`define RELOAD_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL_ONE  4'h0
`define OFS_CONTROL_TWO  4'h1
`define OFS_HIGH_BITS    4'h2
`define OFS_RELOAD_LOW   4'h3
`define OFS_DUTY_LOW     4'h4
`define OFS_PRESCALE_RB  4'h5
`define OFS_BUZZER_CTRL  4'h6
`define OFS_IRQ_FLAG     4'h7
`define OFS_IRQ_ENABLE   4'h8
`define OFS_GLOBAL_IRQ   4'h9

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_RUN_ENABLE   0
`define BIT_RELOAD_SEL   1
`define BIT_ONE_SHOT     2
`define BIT_PWM_LOW      6
`define BIT_PWM_OE       7
`define BIT_PRESC_EN_N   3
`define BIT_EDGE_SEL     4
`define BIT_SRC_SEL      5
`define BIT_BUZZER_EN    7
`define BIT_BUZ_SRC      3
`define BIT_RELOAD_HI    6
`define BIT_DUTY_HI      2
`define BIT_GLOBAL_IRQ   0

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_COUNT        10'h3ff
`define FULL_SCALE       10'h3ff
`define ZERO_COUNT       10'h000
`define INSTR_DIV        2'h1

`endif

// [pkg/reload_timer_pkg.sv]
// Purpose: Types shared by the reload down-counter and its helpers.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only.
package reload_timer_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } pin_drive_type;

  typedef enum logic {
    COUNT_RUN,
    COUNT_STOPPED
  } run_state_type;

endpackage : reload_timer_pkg

// [rtl/ratio_divider.sv]
// Purpose: Divides a one-cycle tick stream by two to the power (sel + 1).
// Assumes: Ticks are one-cycle pulses on the system clock.
// Notes:   Count value is visible for readback.
module ratio_divider (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       clear_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] sel_i,
  // Results
  output logic            tick_o,
  output logic [7:0]      count_o
);

  logic [7:0] next_count;
  logic [7:0] limit;

  assign limit      = 8'((9'h002 << sel_i) - 9'h001);
  assign next_count = count_o + 8'h01;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || clear_i) begin
      count_o <= 8'h00;
      tick_o  <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count_o >= limit) begin
          count_o <= 8'h00;
          tick_o  <= 1'b1;
        end else begin
          count_o <= next_count;
        end
      end
    end
  end

endmodule : ratio_divider

// [rtl/buzzer_gen.sv]
// Purpose: Square-wave buzzer from a selected tick source.
// Assumes: Source ticks are one-cycle pulses.
// Notes:   Output toggles once per divided period.
`include "reload_timer_defines.svh"
module buzzer_gen (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Sources and control
  input  wire logic       enable_i,
  input  wire logic       presc_tick_i,
  input  wire logic       timer_tick_i,
  input  wire logic [3:0] freq_sel_i,
  // Waveform
  output logic            wave_o
);

  logic       src_tick;
  logic       div_tick;

  assign src_tick = freq_sel_i[`BIT_BUZ_SRC] ? timer_tick_i : presc_tick_i;

  ratio_divider u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (!enable_i),
    .tick_i    (src_tick),
    .sel_i     (freq_sel_i[2:0]),
    .tick_o    (div_tick),
    .count_o   ()
  );

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !enable_i) begin
      wave_o <= 1'b0;
    end else if (div_tick) begin
      wave_o <= !wave_o;
    end
  end

endmodule : buzzer_gen

// [testbench/reload_timer_asserts.sv]
// Purpose: Port-level checks of the reload down-counter.
// Assumes: Enables and run bit are mirrored from register writes seen on the bus.
// Notes:   Attached to every instance of the top module by the bind below.
module reload_timer_asserts #(
  parameter int FLAG_BIT = 5,
  parameter int IE_BIT   = 5
) (
  // Clock and reset
  input wire logic                          clk_sys_i,
  input wire logic                          rst_n_i,
  // Register port
  input wire reload_timer_pkg::bus_req_type bus_i,
  input wire logic [7:0]                    rdata_o,
  // Pins and interrupt
  input wire logic                          external_count_pin_i,
  input wire reload_timer_pkg::pin_drive_type pin_o,
  input wire logic                          irq_o,
  input wire logic                          underflow_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import reload_timer_pkg::*;

  logic run_m, ie_m, gie_m, pwm_m, buz_m, en_m, clr;

  assign en_m = pwm_m | buz_m;
  assign clr  = bus_i.wr && bus_i.addr == 4'h7 && !bus_i.wdata[FLAG_BIT];

  // The mirrors update on the same edge as the design, so relations line up cycle for cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {run_m, ie_m, gie_m, pwm_m, buz_m} <= 5'h00;
    end else if (bus_i.wr) begin
      if (bus_i.addr == 4'h0) {pwm_m, run_m} <= {bus_i.wdata[7], bus_i.wdata[0]};
      if (bus_i.addr == 4'h6) buz_m <= bus_i.wdata[7];
      if (bus_i.addr == 4'h8) ie_m <= bus_i.wdata[IE_BIT];
      if (bus_i.addr == 4'h9) gie_m <= bus_i.wdata[0];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  irq_gate_a: assert property (
    irq_o == $past(underflow_flag_o && ie_m && gie_m)) else $error("irq not gated by enables");
  flag_fall_a: assert property (
    $fell(underflow_flag_o) |-> $past(clr)) else $error("flag fell without a clear");
  flag_src_a: assert property (
    $rose(underflow_flag_o) |-> $past(run_m)) else $error("underflow while stopped");
  clear_a: assert property (
    clr && !run_m && !$past(run_m) |=> !underflow_flag_o) else $error("flag not cleared");
  oe_on_a: assert property (
    en_m [*3] |-> pin_o.pin_oe) else $error("pin not driven while enabled");
  oe_off_a: assert property (
    !en_m [*3] |-> !pin_o.pin_oe) else $error("pin driven while disabled");
  rd_idle_a: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00) else $error("read data outside its cycle");
  gie_rd_a: assert property (
    $past(bus_i.rd && bus_i.addr == 4'h9) |-> rdata_o[0] == $past(gie_m))
    else $error("global enable readback wrong");
endmodule : reload_timer_asserts

bind reload_downcounter_pwm_buzzer reload_timer_asserts #(
  .FLAG_BIT(FLAG_BIT), .IE_BIT(IE_BIT)
) reload_timer_asserts_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .external_count_pin_i(external_count_pin_i), .pin_o(pin_o), .irq_o(irq_o),
  .underflow_flag_o(underflow_flag_o)
);

// [testbench/pin_partner.sv]
// Purpose: Far side of the block: drives the count pin, watches the shared pin.
// Assumes: Pin levels change just after a rising clock edge.
// Notes:   The count pin stands still between set_level calls, as a real source would.
module pin_partner (
  // Clock
  input  wire logic                            clk_sys_i,
  // Shared pin from the block
  input  wire reload_timer_pkg::pin_drive_type pad_i,
  // Count pin to the block
  output logic                                 count_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import reload_timer_pkg::*;

  initial count_pin_o = 1'b0;

  task automatic set_level(input logic lvl);
    @(posedge clk_sys_i);
    count_pin_o <= lvl;
  endtask : set_level

  // Counts high samples and level changes of the pin over n settled cycles.
  task automatic watch(input int n, output int highs, output int flips);
    logic last;
    highs = 0;
    flips = 0;
    last  = pad_i.pin_out;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      if (pad_i.pin_out === 1'b1) highs++;
      if (pad_i.pin_out !== last) flips++;
      last = pad_i.pin_out;
    end
  endtask : watch
endmodule : pin_partner

// [testbench/tb.sv]
// Purpose: Self-checking bench of the reload down-counter.
// Assumes: Instruction tick every clock; register map as handed over.
// Notes:   Ratios are judged by underflow periods, which do not depend on phase.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import reload_timer_pkg::*;

  logic          clk_sys_i = 1'b0;
  logic          rst_n_i   = 1'b0;
  bus_req_type   bus       = '0;
  logic [7:0]    rdata;
  logic          ext_pin;
  logic          irq;
  logic          flag;
  pin_drive_type pin;
  logic [7:0]    rdata3;
  logic          irq3;
  logic          flag3;
  int            error_cnt = 0;
  int            checked   = 0;
  int            cyc       = 0;
  int            n;
  int            hi;
  logic [7:0]    v;
  logic [7:0]    w;

  reload_downcounter_pwm_buzzer reload_downcounter_pwm_buzzer_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
    .external_count_pin_i(ext_pin), .pin_o(pin), .irq_o(irq), .underflow_flag_o(flag));
  pin_partner pin_partner_i (.clk_sys_i(clk_sys_i), .pad_i(pin), .count_pin_o(ext_pin));
  // Third-timer layout on the same bus: flag in bit 4, interrupt enable in bit 0.
  reload_downcounter_pwm_buzzer #(
    .FLAG_BIT(4),
    .IE_BIT  (0)
  ) reload_downcounter_pwm_buzzer_third_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata3),
    .external_count_pin_i(ext_pin), .pin_o(), .irq_o(irq3), .underflow_flag_o(flag3));

  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("read data", e, d)
  endtask : chk_rd
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : idle
  task automatic wait_flag();
    int k;
    k = 0;
    while (flag !== 1'b1 && k < 3000) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    `CHK("underflow flag", 1'b1, flag)
  endtask : wait_flag
  // Two clears are needed: the first wait may end on a frame already under way.
  task automatic period(output int p);
    int t;
    wr(4'h7, 8'h00);
    wait_flag();
    t = cyc;
    wr(4'h7, 8'h00);
    wait_flag();
    p = cyc - t;
  endtask : period

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset_load();
    chk_rd(4'h3, 8'hff);
    rd(4'h2, v);
    `CHK("count high", 2'b11, v[7:6])
    chk_rd(4'hf, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h05);
    chk_rd(4'h3, 8'h05);
    idle(10);
    chk_rd(4'h3, 8'h05);
    $display("t_reset_load done");
  endtask : t_reset_load
  task automatic t_cont();
    wr(4'h1, 8'h08);
    wr(4'h0, 8'h03);
    period(n);
    `CHK("reload period", 6, n)
    wr(4'h3, 8'h09);
    rd(4'h3, v);
    `CHK("no early load", 1'b1, v <= 8'h05)
    period(n);
    `CHK("new reload period", 10, n)
    wr(4'h0, 8'h01);
    period(n);
    `CHK("full scale period", 1024, n)
    $display("t_cont done");
  endtask : t_cont
  task automatic t_oneshot();
    wr(4'h0, 8'h00);
    wr(4'h7, 8'h00);
    `CHK("flag cleared", 1'b0, flag)
    wr(4'h3, 8'h03);
    wr(4'h8, 8'h20);
    wr(4'h0, 8'h05);
    wait_flag();
    idle(2);
    `CHK("irq masked", 1'b0, irq)
    wr(4'h9, 8'h01);
    idle(2);
    `CHK("irq raised", 1'b1, irq)
    chk_rd(4'h9, 8'h01);
    `CHK("third flag", 1'b1, flag3)
    `CHK("third irq masked", 1'b0, irq3)
    wr(4'h8, 8'h21);
    idle(2);
    `CHK("third irq raised", 1'b1, irq3)
    rd(4'h7, v);
    `CHK("flag register", 8'h20, v)
    `CHK("third flag register", 8'h10, rdata3)
    wr(4'h7, 8'h00);
    idle(20);
    `CHK("single underflow", 1'b0, flag)
    `CHK("irq dropped", 1'b0, irq)
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h00);
    $display("t_oneshot done");
  endtask : t_oneshot
  task automatic t_ext();
    wr(4'h3, 8'h03);
    wr(4'h1, 8'h28);
    wr(4'h0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr(4'h1, 8'h38);
      pin_partner_i.set_level(~i[0]);
      idle(4);
      chk_rd(4'h3, (i == 3) ? 8'h01 : 8'h02);
    end
    wr(4'h0, 8'h00);
    $display("t_ext done");
  endtask : t_ext
  task automatic t_presc();
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h03);
    period(n);
    `CHK("ratio 8 period", 16, n)
    wr(4'h1, 8'h07);
    period(n);
    `CHK("ratio 256 period", 512, n)
    rd(4'h5, v);
    rd(4'h5, w);
    `CHK("prescaler moves", 1'b1, v != w)
    $display("t_presc done");
  endtask : t_presc
  task automatic t_pwm();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h08);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h09);
    wr(4'h4, 8'h03);
    wr(4'h0, 8'h83);
    idle(30);
    pin_partner_i.watch(20, hi, n);
    `CHK("active high count", 6, hi)
    `CHK("pwm drives pin", 1'b1, pin.pin_oe)
    wr(4'h0, 8'hc3);
    idle(4);
    pin_partner_i.watch(20, hi, n);
    `CHK("active low count", 14, hi)
    wr(4'h4, 8'h00);
    idle(30);
    pin_partner_i.watch(20, hi, n);
    `CHK("duty zero idle", 20, hi)
    $display("t_pwm done");
  endtask : t_pwm
  task automatic t_buz();
    wr(4'h0, 8'h03);
    wr(4'h3, 8'h01);
    wr(4'h6, 8'h88);
    idle(30);
    pin_partner_i.watch(40, hi, n);
    `CHK("buzzer flips", 10, n)
    `CHK("buzzer drives pin", 1'b1, pin.pin_oe)
    wr(4'h0, 8'h83);
    idle(4);
    pin_partner_i.watch(20, hi, n);
    `CHK("pwm over buzzer", 0, n)
    // Prescaler by 4 feeding a buzzer divide by 4 gives one toggle every 16 clocks.
    wr(4'h0, 8'h03);
    wr(4'h1, 8'h01);
    wr(4'h6, 8'h81);
    idle(40);
    pin_partner_i.watch(64, hi, n);
    `CHK("prescaler buzzer flips", 4, n)
    $display("t_buz done");
  endtask : t_buz

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_load();
    t_cont();
    t_oneshot();
    t_ext();
    t_presc();
    t_pwm();
    t_buz();
    print_verdict();
  end
endmodule : tb
